// ==== rmsc_cfg.svh ====
// Constants for the radio operating-mode controller
`ifndef RMSC_CFG_SVH
`define RMSC_CFG_SVH

`define RMSC_CLK_MHZ 125
`define RMSC_CNT_W 32
`define RMSC_RETRY_W 4
`define RMSC_CE_START_NS 10000
`define RMSC_CE_START_CYC ((`RMSC_CE_START_NS * `RMSC_CLK_MHZ + 999) / 1000)
`define RMSC_CS_FILTER_US 128
`define RMSC_CS_FILTER_CYC (`RMSC_CS_FILTER_US * `RMSC_CLK_MHZ)
`define RMSC_RETRY_STEP_US 250
`define RMSC_RETRY_STEP_CYC (`RMSC_RETRY_STEP_US * `RMSC_CLK_MHZ)
`define RMSC_CNT_RESET 32'h0000_0000
`define RMSC_RETRY_RESET 4'h0

`endif

// ==== rmsc_pkg.sv ====
// Types for the radio operating-mode controller
`include "rmsc_cfg.svh"

package rmsc_pkg;

	typedef enum logic [2:0] {
		RMSC_PWR_DOWN,
		RMSC_STANDBY_1,
		RMSC_STANDBY_2,
		RMSC_TX,
		RMSC_RX
	} rmsc_mode_t;

	typedef struct packed {
		rmsc_mode_t mode;
		logic ce_s1;
		logic ce_s2;
		logic rf_s1;
		logic rf_s2;
		logic [`RMSC_CNT_W-1:0] ce_cnt;
		logic [`RMSC_CNT_W-1:0] cs_cnt;
		logic [`RMSC_CNT_W-1:0] dly_cnt;
		logic [`RMSC_RETRY_W-1:0] retry_cnt;
		logic retry_pend;
		logic awaiting_ack;
		logic exhausted;
		logic carrier;
		logic tx_start;
		logic tx_resend;
		logic ack_mode;
		logic ack_payload;
		logic rx_write;
		logic rx_drop;
		logic retry_irq;
	} rmsc_state_t;

endpackage

// ==== rmsc_mode_ctrl.sv ====
// Operating-mode state machine of the packet transceiver
`timescale 1ns/100ps
`include "rmsc_cfg.svh"

module rmsc_mode_ctrl
	import rmsc_pkg::*;
#(
	parameter int unsigned CS_FILTER_CYC = `RMSC_CS_FILTER_CYC,
	parameter int unsigned RETRY_STEP_CYC = `RMSC_RETRY_STEP_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic power_on_bit,
	input wire logic receive_role_select,
	input wire logic auto_ack_enable,
	input wire logic [`RMSC_RETRY_W-1:0] retry_limit,
	input wire logic [`RMSC_RETRY_W-1:0] retry_delay,
	input wire logic retry_flag_clear,
	input wire logic radio_activate_pin,
	input wire logic rf_signal_present,
	input wire logic tx_fifo_empty,
	input wire logic tx_skip_ack,
	input wire logic tx_done,
	input wire logic ack_received,
	input wire logic ack_timeout,
	input wire logic rx_packet_valid,
	input wire logic rx_addr_match,
	input wire logic rx_crc_ok,
	input wire logic rx_skip_ack,
	input wire logic rx_fifo_full,
	output rmsc_mode_t mode,
	output logic tx_start,
	output logic tx_resend,
	output logic ack_mode,
	output logic ack_payload,
	output logic rx_fifo_write,
	output logic rx_discard,
	output logic carrier_sense,
	output logic [`RMSC_RETRY_W-1:0] retry_counter,
	output logic retry_exhausted_flag,
	output logic retry_irq
);

	localparam logic [`RMSC_CNT_W-1:0] CE_START_CYC = `RMSC_CNT_W'(`RMSC_CE_START_CYC);
	localparam logic [`RMSC_CNT_W-1:0] CS_CYC = `RMSC_CNT_W'(CS_FILTER_CYC);
	localparam logic [`RMSC_CNT_W-1:0] STEP_CYC = `RMSC_CNT_W'(RETRY_STEP_CYC);
	localparam logic [`RMSC_CNT_W-1:0] CNT_ONE = `RMSC_CNT_W'(1);

	rmsc_state_t s_q;
	rmsc_state_t s_d;

	logic ce;
	logic rf;
	logic ce_started;
	logic rx_good;
	logic [`RMSC_CNT_W-1:0] dly_target;

	assign ce = s_q.ce_s2;
	assign rf = s_q.rf_s2;
	// Held strictly longer than the start time
	assign ce_started = ce && (s_q.ce_cnt > CE_START_CYC);
	assign rx_good = rx_packet_valid && rx_addr_match && rx_crc_ok;
	assign dly_target = `RMSC_CNT_W'(({{(`RMSC_CNT_W-`RMSC_RETRY_W){1'b0}}, retry_delay} + CNT_ONE) * STEP_CYC);

	always_comb begin
		s_d = s_q;
		s_d.ce_s1 = radio_activate_pin;
		s_d.ce_s2 = s_q.ce_s1;
		s_d.rf_s1 = rf_signal_present;
		s_d.rf_s2 = s_q.rf_s1;
		s_d.tx_start = 1'b0;
		s_d.tx_resend = 1'b0;
		s_d.rx_write = 1'b0;
		s_d.rx_drop = 1'b0;
		s_d.retry_irq = 1'b0;

		// Pulse width of the synchronised activate pin
		if (!ce) begin
			s_d.ce_cnt = `RMSC_CNT_RESET;
		end else if (s_q.ce_cnt <= CE_START_CYC) begin
			s_d.ce_cnt = s_q.ce_cnt + CNT_ONE;
		end

		// Filtered carrier sense, receive mode only
		if (s_q.mode != RMSC_RX || !rf) begin
			s_d.cs_cnt = `RMSC_CNT_RESET;
			s_d.carrier = 1'b0;
		end else if (s_q.cs_cnt < CS_CYC) begin
			s_d.cs_cnt = s_q.cs_cnt + CNT_ONE;
			s_d.carrier = 1'b0;
		end else begin
			s_d.carrier = 1'b1;
		end

		// Sticky flag; a new set wins over the clear
		if (retry_flag_clear) begin
			s_d.exhausted = 1'b0;
		end

		unique case (s_q.mode)
			RMSC_PWR_DOWN: begin
				// Only the power bit changes the mode; retry_flag_clear still clears the flag and the pin synchronisers keep sampling
				if (power_on_bit) begin
					s_d.mode = RMSC_STANDBY_1;
				end
			end
			RMSC_STANDBY_1: begin
				if (s_q.retry_pend) begin
					if (s_q.dly_cnt + CNT_ONE >= dly_target) begin
						s_d.dly_cnt = `RMSC_CNT_RESET;
						s_d.retry_pend = 1'b0;
						s_d.retry_cnt = s_q.retry_cnt + `RMSC_RETRY_W'(1);
						s_d.mode = RMSC_TX;
						s_d.tx_start = 1'b1;
						s_d.tx_resend = 1'b1;
						s_d.awaiting_ack = 1'b1;
					end else begin
						s_d.dly_cnt = s_q.dly_cnt + CNT_ONE;
					end
				end else if (receive_role_select) begin
					if (ce) begin
						s_d.mode = RMSC_RX;
					end
				end else if (ce_started) begin
					if (tx_fifo_empty) begin
						s_d.mode = RMSC_STANDBY_2;
					end else begin
						s_d.mode = RMSC_TX;
						s_d.tx_start = 1'b1;
						s_d.retry_cnt = `RMSC_RETRY_RESET;
						s_d.awaiting_ack = auto_ack_enable && !tx_skip_ack;
					end
				end
			end
			RMSC_STANDBY_2: begin
				if (!ce || receive_role_select) begin
					s_d.mode = RMSC_STANDBY_1;
				end else if (!tx_fifo_empty) begin
					s_d.mode = RMSC_TX;
					s_d.tx_start = 1'b1;
					s_d.retry_cnt = `RMSC_RETRY_RESET;
					s_d.awaiting_ack = auto_ack_enable && !tx_skip_ack;
				end
			end
			RMSC_TX: begin
				// Packet in progress completes unless the power bit goes low
				if (tx_done) begin
					if (s_q.ack_mode) begin
						s_d.ack_mode = 1'b0;
						s_d.ack_payload = 1'b0;
						s_d.mode = ce ? RMSC_RX : RMSC_STANDBY_1;
					end else if (s_q.awaiting_ack) begin
						s_d.mode = RMSC_RX;
					end else if (auto_ack_enable && tx_skip_ack) begin
						s_d.mode = RMSC_STANDBY_1;
					end else if (!ce) begin
						s_d.mode = RMSC_STANDBY_1;
					end else if (!tx_fifo_empty) begin
						s_d.tx_start = 1'b1;
						s_d.retry_cnt = `RMSC_RETRY_RESET;
						s_d.awaiting_ack = auto_ack_enable && !tx_skip_ack;
					end else begin
						s_d.mode = RMSC_STANDBY_2;
					end
				end
			end
			RMSC_RX: begin
				if (s_q.awaiting_ack) begin
					// Transmitter listening for its acknowledgement
					if (ack_received) begin
						s_d.awaiting_ack = 1'b0;
						if (!ce) begin
							s_d.mode = RMSC_STANDBY_1;
						end else if (!tx_fifo_empty) begin
							s_d.mode = RMSC_TX;
							s_d.tx_start = 1'b1;
							s_d.retry_cnt = `RMSC_RETRY_RESET;
							s_d.awaiting_ack = auto_ack_enable && !tx_skip_ack;
						end else begin
							s_d.mode = RMSC_STANDBY_2;
						end
					end else if (ack_timeout) begin
						s_d.mode = RMSC_STANDBY_1;
						s_d.dly_cnt = `RMSC_CNT_RESET;
						if (s_q.retry_cnt < retry_limit) begin
							s_d.retry_pend = 1'b1;
						end else begin
							s_d.awaiting_ack = 1'b0;
							s_d.exhausted = 1'b1;
							s_d.retry_irq = 1'b1;
						end
					end
				end else if (!ce || !receive_role_select) begin
					s_d.mode = RMSC_STANDBY_1;
				end else if (rx_good) begin
					if (rx_fifo_full) begin
						s_d.rx_drop = 1'b1;
					end else begin
						s_d.rx_write = 1'b1;
						if (auto_ack_enable && !rx_skip_ack) begin
							s_d.mode = RMSC_TX;
							s_d.tx_start = 1'b1;
							s_d.ack_mode = 1'b1;
							s_d.ack_payload = !tx_fifo_empty;
						end
					end
				end
			end
		endcase

		// Power bit low overrides the mode and every output pulse except retry_irq
		if (!power_on_bit) begin
			s_d.mode = RMSC_PWR_DOWN;
			s_d.tx_start = 1'b0;
			s_d.tx_resend = 1'b0;
			s_d.rx_write = 1'b0;
			s_d.rx_drop = 1'b0;
			s_d.retry_pend = 1'b0;
			s_d.awaiting_ack = 1'b0;
			s_d.ack_mode = 1'b0;
			s_d.ack_payload = 1'b0;
			s_d.dly_cnt = `RMSC_CNT_RESET;
			s_d.cs_cnt = `RMSC_CNT_RESET;
			s_d.carrier = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			// Every field listed so a new one cannot slip past reset
			s_q <= '{
				mode: RMSC_PWR_DOWN,
				ce_s1: 1'b0,
				ce_s2: 1'b0,
				rf_s1: 1'b0,
				rf_s2: 1'b0,
				ce_cnt: `RMSC_CNT_RESET,
				cs_cnt: `RMSC_CNT_RESET,
				dly_cnt: `RMSC_CNT_RESET,
				retry_cnt: `RMSC_RETRY_RESET,
				retry_pend: 1'b0,
				awaiting_ack: 1'b0,
				exhausted: 1'b0,
				carrier: 1'b0,
				tx_start: 1'b0,
				tx_resend: 1'b0,
				ack_mode: 1'b0,
				ack_payload: 1'b0,
				rx_write: 1'b0,
				rx_drop: 1'b0,
				retry_irq: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign mode = s_q.mode;
	assign tx_start = s_q.tx_start;
	assign tx_resend = s_q.tx_resend;
	assign ack_mode = s_q.ack_mode;
	assign ack_payload = s_q.ack_payload;
	assign rx_fifo_write = s_q.rx_write;
	assign rx_discard = s_q.rx_drop;
	assign carrier_sense = s_q.carrier;
	assign retry_counter = s_q.retry_cnt;
	assign retry_exhausted_flag = s_q.exhausted;
	assign retry_irq = s_q.retry_irq;

endmodule

// ==== rmsc_mode_ctrl_chk.sv ====
// Assertion checker for the radio mode controller
`timescale 1ns/100ps
module rmsc_mode_ctrl_chk
	import rmsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic power_on_bit,
	input wire logic receive_role_select,
	input wire logic auto_ack_enable,
	input wire logic radio_activate_pin,
	input wire logic tx_done,
	input wire logic tx_skip_ack,
	input wire logic rx_packet_valid,
	input wire logic rx_addr_match,
	input wire logic rx_crc_ok,
	input wire logic rx_fifo_full,
	input rmsc_mode_t mode,
	input wire logic tx_start,
	input wire logic tx_resend,
	input wire logic rx_fifo_write,
	input wire logic rx_discard,
	input wire logic carrier_sense,
	input wire logic retry_exhausted_flag,
	input wire logic retry_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	pwr_down_a: assert property (!power_on_bit |=> mode == RMSC_PWR_DOWN)
		else $error("power down missed");
	wake_up_a: assert property (mode == RMSC_PWR_DOWN && power_on_bit |=> mode == RMSC_STANDBY_1)
		else $error("standby missed");
	start_tx_a: assert property (tx_start |-> mode == RMSC_TX)
		else $error("start outside transmit");
	resend_pair_a: assert property (tx_resend |-> tx_start)
		else $error("resend without start");
	rx_take_a: assert property (mode == RMSC_RX && power_on_bit && receive_role_select
		&& rx_packet_valid && rx_addr_match && rx_crc_ok && !rx_fifo_full
		|=> rx_fifo_write && !rx_discard)
		else $error("valid packet not stored");
	rx_full_a: assert property (mode == RMSC_RX && power_on_bit && receive_role_select
		&& rx_packet_valid && rx_addr_match && rx_crc_ok && rx_fifo_full
		|=> rx_discard && !rx_fifo_write)
		else $error("full fifo not discarded");
	carrier_a: assert property (mode != RMSC_RX |=> !carrier_sense)
		else $error("carrier outside receive");
	rx_leave_a: assert property ((mode == RMSC_RX && receive_role_select && !radio_activate_pin) [*3]
		|=> mode != RMSC_RX)
		else $error("receive kept with pin low");
	ptx_noack_a: assert property (mode == RMSC_TX && tx_done && !receive_role_select
		&& (!auto_ack_enable || tx_skip_ack) |=> mode != RMSC_RX)
		else $error("listened without ack");
	irq_pulse_a: assert property (retry_irq |-> retry_exhausted_flag ##1 !retry_irq)
		else $error("retry irq bad");
endmodule
bind rmsc_mode_ctrl rmsc_mode_ctrl_chk u_chk (.*);

// ==== rmsc_engine_model.sv ====
// Packet engine model ending packets and ack waits
`timescale 1ns/100ps
module rmsc_engine_model
	import rmsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input rmsc_mode_t mode,
	input wire logic tx_start,
	input wire logic slow,
	input wire logic ack_wait,
	output logic tx_done,
	output logic ack_timeout
);
	rmsc_mode_t last_q;
	logic [7:0] cnt_q;
	wire logic [7:0] len = slow ? 8'h28 : 8'h08;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			last_q <= RMSC_PWR_DOWN;
			cnt_q <= 8'h00;
			tx_done <= 1'b0;
			ack_timeout <= 1'b0;
		end else begin
			last_q <= mode;
			cnt_q <= (mode != last_q || tx_start) ? 8'h00 : cnt_q + 8'h01;
			tx_done <= mode == RMSC_TX && cnt_q == len;
			ack_timeout <= mode == RMSC_RX && ack_wait && cnt_q == len;
		end
	end
endmodule

// ==== rmsc_mode_ctrl_bench.sv ====
// Self-checking testbench of the radio mode controller
`timescale 1ns/100ps
module rmsc_mode_ctrl_bench;
	import rmsc_pkg::*;
	logic sys_clk, resetn, power_on_bit, receive_role_select, auto_ack_enable, retry_flag_clear, radio_activate_pin;
	logic rf_signal_present, tx_fifo_empty, tx_skip_ack, tx_done, ack_received, ack_timeout, rx_packet_valid;
	logic rx_addr_match, rx_crc_ok, rx_skip_ack, rx_fifo_full, tx_start, tx_resend, ack_mode, ack_payload;
	logic rx_fifo_write, rx_discard, carrier_sense, retry_exhausted_flag, retry_irq, slow, ack_wait;
	logic [3:0] retry_limit, retry_delay, retry_counter;
	rmsc_mode_t mode;
	int n_fail, n_compared, waited, cyc;
	rmsc_mode_ctrl #(.CS_FILTER_CYC(20), .RETRY_STEP_CYC(10)) dut (.*);
	rmsc_engine_model eng (.*);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic wait_mode(input rmsc_mode_t m, input int lim);
		waited = 0;
		@(negedge sys_clk);
		while (mode !== m && waited < lim) begin
			waited++;
			@(negedge sys_clk);
		end
		n_compared++;
		if (mode !== m) begin
			n_fail++;
			$display("BAD mode expected %0d seen %0d", m, mode);
		end
	endtask
	task automatic pkt(input logic m, input logic c, input logic f);
		@(posedge sys_clk);
		rx_packet_valid <= 1'b1;
		rx_addr_match <= m;
		rx_crc_ok <= c;
		rx_fifo_full <= f;
		@(posedge sys_clk);
		rx_packet_valid <= 1'b0;
		rx_fifo_full <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic t_ptx();
		@(posedge sys_clk);
		power_on_bit <= 1'b1;
		wait_mode(RMSC_STANDBY_1, 3);
		@(posedge sys_clk);
		tx_fifo_empty <= 1'b0;
		radio_activate_pin <= 1'b1;
		repeat (600) @(posedge sys_clk);
		radio_activate_pin <= 1'b0;
		repeat (10) @(posedge sys_clk);
		radio_activate_pin <= 1'b1;
		slow <= 1'b1;
		wait_mode(RMSC_TX, 1400);
		chk("start delay", 1'b1, waited >= 1250);
		chk("start", 1'b1, tx_start);
		@(posedge sys_clk);
		tx_fifo_empty <= 1'b1;
		wait_mode(RMSC_STANDBY_2, 80);
		@(posedge sys_clk);
		slow <= 1'b0;
		tx_fifo_empty <= 1'b0;
		wait_mode(RMSC_TX, 4);
		@(posedge sys_clk);
		radio_activate_pin <= 1'b0;
		tx_fifo_empty <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wait_mode(RMSC_TX, 0);
		wait_mode(RMSC_STANDBY_1, 20);
		$display("transmit test done");
	endtask
	task automatic t_retry();
		@(posedge sys_clk);
		auto_ack_enable <= 1'b1;
		ack_wait <= 1'b1;
		retry_limit <= 4'h1;
		retry_delay <= 4'h1;
		tx_fifo_empty <= 1'b0;
		radio_activate_pin <= 1'b1;
		wait_mode(RMSC_TX, 1400);
		@(posedge sys_clk);
		radio_activate_pin <= 1'b0;
		wait_mode(RMSC_RX, 20);
		wait_mode(RMSC_STANDBY_1, 20);
		wait_mode(RMSC_TX, 40);
		chk("resend", 1'b1, tx_resend);
		chk("retries", 1'b1, retry_counter === 4'h1);
		wait_mode(RMSC_RX, 20);
		wait_mode(RMSC_STANDBY_1, 20);
		chk("irq", 1'b1, retry_irq);
		@(negedge sys_clk);
		chk("exhausted", 1'b1, retry_exhausted_flag);
		@(posedge sys_clk);
		retry_flag_clear <= 1'b1;
		auto_ack_enable <= 1'b0;
		ack_wait <= 1'b0;
		tx_fifo_empty <= 1'b1;
		@(posedge sys_clk);
		retry_flag_clear <= 1'b0;
		@(negedge sys_clk);
		chk("flag clear", 1'b0, retry_exhausted_flag);
		$display("retry test done");
	endtask
	task automatic t_prx();
		@(posedge sys_clk);
		receive_role_select <= 1'b1;
		auto_ack_enable <= 1'b1;
		radio_activate_pin <= 1'b1;
		tx_fifo_empty <= 1'b0;
		wait_mode(RMSC_RX, 6);
		pkt(1'b1, 1'b1, 1'b0);
		chk("write", 1'b1, rx_fifo_write);
		chk("ack", 1'b1, ack_mode);
		chk("ack payload", 1'b1, ack_payload);
		wait_mode(RMSC_RX, 20);
		pkt(1'b1, 1'b0, 1'b0);
		chk("bad crc", 1'b0, rx_fifo_write);
		pkt(1'b0, 1'b1, 1'b0);
		chk("bad addr", 1'b0, rx_fifo_write);
		pkt(1'b1, 1'b1, 1'b1);
		chk("discard", 1'b1, rx_discard);
		@(posedge sys_clk);
		auto_ack_enable <= 1'b0;
		pkt(1'b1, 1'b1, 1'b0);
		wait_mode(RMSC_RX, 0);
		@(posedge sys_clk);
		rf_signal_present <= 1'b1;
		waited = 0;
		while (carrier_sense !== 1'b1 && waited < 40) begin
			@(negedge sys_clk);
			waited++;
		end
		chk("carrier", 1'b1, carrier_sense);
		chk("carrier delay", 1'b1, waited >= 20);
		@(posedge sys_clk);
		radio_activate_pin <= 1'b0;
		wait_mode(RMSC_STANDBY_1, 6);
		@(posedge sys_clk);
		radio_activate_pin <= 1'b1;
		wait_mode(RMSC_RX, 6);
		@(posedge sys_clk);
		power_on_bit <= 1'b0;
		wait_mode(RMSC_PWR_DOWN, 2);
		$display("receive test done");
	endtask
	task automatic wrap_up();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		{resetn, power_on_bit, receive_role_select, auto_ack_enable, retry_flag_clear, radio_activate_pin} = '0;
		{rf_signal_present, tx_skip_ack, ack_received, rx_packet_valid, rx_addr_match, rx_crc_ok} = '0;
		{rx_skip_ack, rx_fifo_full, slow, ack_wait, retry_limit, retry_delay} = '0;
		tx_fifo_empty = 1'b1;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_ptx();
		t_retry();
		t_prx();
		wrap_up();
	end
endmodule
